// ==== design/afecr_pkg.sv ====
// Package: addresses, field layout, reset values and carrier types for the front end config registers
package afecr_pkg;

  // ==========================================================================
  // Register access
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] BUF_CTRL_ADDR = 8'h16;
  localparam logic [7:0] CM_CHOP_ADDR  = 8'h17;

  localparam logic [7:0] BUF_CTRL_RESET = 8'h00;
  localparam logic [7:0] CM_CHOP_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Writable bits; reserved positions are zero here
  localparam logic [7:0] BUF_CTRL_WMASK = 8'hf3;
  localparam logic [7:0] CM_CHOP_WMASK  = 8'h87;

  // ==========================================================================
  // Field positions
  localparam int unsigned POS_REF_LSB      = 6;
  localparam int unsigned NEG_REF_LSB      = 4;
  localparam int unsigned POS_IN_DIS_BIT   = 1;
  localparam int unsigned NEG_IN_DIS_BIT   = 0;
  localparam int unsigned CHOP_BIT         = 7;
  localparam int unsigned CM_SEL_LSB       = 0;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] REF_PRECHARGE  = 2'h0;
  localparam logic [1:0] REF_UNBUFFERED = 2'h1;
  localparam logic [1:0] REF_FULL       = 2'h2;

  localparam logic [2:0] CM_HALF_SUPPLY = 3'h0;
  localparam logic [2:0] CM_OFF         = 3'h7;

  localparam logic [5:0] CHOP_DIV_SLOW = 6'h20;
  localparam logic [5:0] CHOP_DIV_FAST = 6'h08;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afecr_req_type;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } afecr_rsp_type;

  typedef struct packed {
    logic [1:0] pos_reference_buffer_sel;
    logic       pos_ref_precharge_en;
    logic       pos_ref_full_en;
    logic [1:0] neg_reference_buffer_sel;
    logic       neg_ref_precharge_en;
    logic       neg_ref_full_en;
    logic       pos_input_precharge_disable;
    logic       neg_input_precharge_disable;
    logic       chop_fast_sel;
    logic [5:0] chop_divide;
    logic [2:0] common_mode_out_sel;
    logic       common_mode_out_en;
    logic       common_mode_half_supply;
  } afecr_ctrl_type;

endpackage

// ==== design/afecr_field_reg.sv ====
// One 8-bit configuration register with a write mask and a reset value
`timescale 1ns/1ps

module afecr_field_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // Stored value
  output logic      [7:0] q
);

  logic [7:0] value_r;
  logic [7:0] value_nxt;

  // ==========================================================================
  // Next value
  // Masked bits keep their reset value, so reserved bits stay zero
  always_comb begin
    value_nxt = value_r;
    if (wr_en) begin
      value_nxt = (wdata & WMASK) | (RESET_VAL & ~WMASK);
    end
  end

  // ==========================================================================
  // Storage
  always_ff @(posedge clk) begin
    if (reset) begin
      value_r <= RESET_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign q = value_r;

endmodule

// ==== design/afecr_regs.sv ====
// Analog front end configuration registers: buffering, chop rate and common-mode output
//
// What this block does
// (R1) Buffer register at 0x16, eight bits, all zero after reset.
// (R2) Bits 7:6 pick positive reference buffering: 00 precharge, 01 none, 10 full.
// (R3) Bits 5:4 pick negative reference buffering with the same codes.
// (R4) Bit 1 set disables the positive input precharge buffer; resets to zero.
// (R5) Bit 0 set disables the negative input precharge buffer; resets to zero.
// (R6) Common-mode and chop register at 0x17, eight bits, all zero after reset.
// (R7) Bit 7 picks chop rate: zero divides modulator clock by 32, one by 8.
// (R8) Bits 2:0 pick common-mode level: 000 half supply, 111 output off.
// (R9) Reserved bits read zero and ignore writes.
`timescale 1ns/1ps

module afecr_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Register access from the serial port logic
  input  wire afecr_pkg::afecr_req_type req,
  output afecr_pkg::afecr_rsp_type      rsp_r,
  // Enable and select lines into the analog circuits
  output afecr_pkg::afecr_ctrl_type     ctrl_r
);

  logic [7:0]                 buf_q;
  logic [7:0]                 cm_q;
  logic                       buf_wr;
  logic                       cm_wr;
  afecr_pkg::afecr_rsp_type   rsp_nxt;
  afecr_pkg::afecr_ctrl_type  ctrl_nxt;

  // ==========================================================================
  // Address decode
  assign buf_wr = req.wr && (req.addr == afecr_pkg::BUF_CTRL_ADDR); // [R1]
  assign cm_wr  = req.wr && (req.addr == afecr_pkg::CM_CHOP_ADDR);  // [R6]

  // ==========================================================================
  // Storage
  afecr_field_reg #(
    .RESET_VAL (afecr_pkg::BUF_CTRL_RESET),
    .WMASK     (afecr_pkg::BUF_CTRL_WMASK)
  ) u_buf_ctrl (
    .clk   (clk),
    .reset (reset),
    .wr_en (buf_wr),
    .wdata (req.wdata),
    .q     (buf_q)
  ); // [R1] [R9]

  afecr_field_reg #(
    .RESET_VAL (afecr_pkg::CM_CHOP_RESET),
    .WMASK     (afecr_pkg::CM_CHOP_WMASK)
  ) u_cm_chop (
    .clk   (clk),
    .reset (reset),
    .wr_en (cm_wr),
    .wdata (req.wdata),
    .q     (cm_q)
  ); // [R6] [R9]

  // ==========================================================================
  // Reference buffer decode
  // Code 11 is undefined; it is treated as unbuffered, the least active choice
  function automatic logic [1:0] ref_enables(input logic [1:0] code);
    logic [1:0] en;
    en = 2'h0;
    case (code)
      afecr_pkg::REF_PRECHARGE: en = 2'h1;
      afecr_pkg::REF_FULL:      en = 2'h2;
      default:                  en = 2'h0;
    endcase
    return en;
  endfunction

  // ==========================================================================
  // Read path and control lines, next values
  // Reads see the stored value; a write in the same cycle shows on the next read
  always_comb begin
    logic [7:0] b;
    logic [7:0] c;
    logic [1:0] pen;
    logic [1:0] nen;
    b   = buf_q;
    c   = cm_q;
    pen = 2'h0;
    nen = 2'h0;

    rsp_nxt.valid = req.rd;
    rsp_nxt.data  = afecr_pkg::UNMAPPED_READ;
    if (req.rd) begin
      case (req.addr)
        afecr_pkg::BUF_CTRL_ADDR: rsp_nxt.data = buf_q; // [R1] [R9]
        afecr_pkg::CM_CHOP_ADDR:  rsp_nxt.data = cm_q;  // [R6] [R9]
        default:                  rsp_nxt.data = afecr_pkg::UNMAPPED_READ;
      endcase
    end

    ctrl_nxt.pos_reference_buffer_sel = b[afecr_pkg::POS_REF_LSB +: 2]; // [R2]
    pen = ref_enables(b[afecr_pkg::POS_REF_LSB +: 2]);                 // [R2]
    ctrl_nxt.pos_ref_precharge_en = pen[0];
    ctrl_nxt.pos_ref_full_en      = pen[1];

    ctrl_nxt.neg_reference_buffer_sel = b[afecr_pkg::NEG_REF_LSB +: 2]; // [R3]
    nen = ref_enables(b[afecr_pkg::NEG_REF_LSB +: 2]);                 // [R3]
    ctrl_nxt.neg_ref_precharge_en = nen[0];
    ctrl_nxt.neg_ref_full_en      = nen[1];

    ctrl_nxt.pos_input_precharge_disable = b[afecr_pkg::POS_IN_DIS_BIT]; // [R4]
    ctrl_nxt.neg_input_precharge_disable = b[afecr_pkg::NEG_IN_DIS_BIT]; // [R5]

    ctrl_nxt.chop_fast_sel = c[afecr_pkg::CHOP_BIT]; // [R7]
    ctrl_nxt.chop_divide   = c[afecr_pkg::CHOP_BIT] ? afecr_pkg::CHOP_DIV_FAST
                                                    : afecr_pkg::CHOP_DIV_SLOW; // [R7]

    ctrl_nxt.common_mode_out_sel     = c[afecr_pkg::CM_SEL_LSB +: 3];           // [R8]
    ctrl_nxt.common_mode_out_en      = c[afecr_pkg::CM_SEL_LSB +: 3] != afecr_pkg::CM_OFF; // [R8]
    ctrl_nxt.common_mode_half_supply =
      c[afecr_pkg::CM_SEL_LSB +: 3] == afecr_pkg::CM_HALF_SUPPLY; // [R8]
  end

  // ==========================================================================
  // Output flops
  // Reset values match the decode of an all-zero register pair
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_r.valid                        <= 1'b0;
      rsp_r.data                         <= afecr_pkg::UNMAPPED_READ;
      ctrl_r.pos_reference_buffer_sel    <= afecr_pkg::REF_PRECHARGE;
      ctrl_r.pos_ref_precharge_en        <= 1'b1;
      ctrl_r.pos_ref_full_en             <= 1'b0;
      ctrl_r.neg_reference_buffer_sel    <= afecr_pkg::REF_PRECHARGE;
      ctrl_r.neg_ref_precharge_en        <= 1'b1;
      ctrl_r.neg_ref_full_en             <= 1'b0;
      ctrl_r.pos_input_precharge_disable <= 1'b0;
      ctrl_r.neg_input_precharge_disable <= 1'b0;
      ctrl_r.chop_fast_sel               <= 1'b0;
      ctrl_r.chop_divide                 <= afecr_pkg::CHOP_DIV_SLOW;
      ctrl_r.common_mode_out_sel         <= afecr_pkg::CM_HALF_SUPPLY;
      ctrl_r.common_mode_out_en          <= 1'b1;
      ctrl_r.common_mode_half_supply     <= 1'b1;
    end else begin
      rsp_r  <= rsp_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

endmodule

// ==== testbench/afecr_regs_sva.sv ====
// Checker for the front end config registers
`timescale 1ns/1ps
module afecr_regs_sva (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      reset,
  // Watched ports
  input wire afecr_pkg::afecr_req_type  req,
  input wire afecr_pkg::afecr_rsp_type  rsp_r,
  input wire afecr_pkg::afecr_ctrl_type ctrl_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // Write data of two edges back
  logic [15:0] wd_r;
  always_ff @(posedge clk) wd_r <= {wd_r[7:0], req.wdata};
  sequence s_buf_wr; req.wr && req.addr == 8'h16; endsequence
  sequence s_cm_wr; req.wr && req.addr == 8'h17; endsequence
  // ==========
  a_read_valid: assert property (req.rd |=> rsp_r.valid) else $error("no answer");
  a_valid_only_read: assert property (!req.rd |=> !rsp_r.valid) else $error("stray valid");
  a_unmapped_zero: assert property (
    req.rd && req.addr[7:1] != 7'h0b |=> rsp_r.data == 8'h00) else $error("unmapped read");
  a_buf_rsvd_zero: assert property (
    req.rd && req.addr == 8'h16 |=> rsp_r.data[3:2] == 2'h0) else $error("reserved bits");
  a_cm_rsvd_zero: assert property (
    req.rd && req.addr == 8'h17 |=> rsp_r.data[6:3] == 4'h0) else $error("cm reserved bits");
  a_pos_ref_dec: assert property (
    ctrl_r.pos_ref_precharge_en == (ctrl_r.pos_reference_buffer_sel == 2'h0)
    && ctrl_r.pos_ref_full_en == (ctrl_r.pos_reference_buffer_sel == 2'h2)) else $error("pos ref");
  a_neg_ref_dec: assert property (
    ctrl_r.neg_ref_precharge_en == (ctrl_r.neg_reference_buffer_sel == 2'h0)
    && ctrl_r.neg_ref_full_en == (ctrl_r.neg_reference_buffer_sel == 2'h2)) else $error("neg ref");
  a_chop_divide: assert property (
    ctrl_r.chop_divide == (ctrl_r.chop_fast_sel ? 6'h08 : 6'h20)) else $error("chop");
  a_cm_decode: assert property (
    ctrl_r.common_mode_out_en == (ctrl_r.common_mode_out_sel != 3'h7)
    && ctrl_r.common_mode_half_supply == (ctrl_r.common_mode_out_sel == 3'h0)) else $error("cm");
  a_buf_wr_lands: assert property (s_buf_wr ##1 !(req.wr && req.addr == 8'h16) |=>
    {ctrl_r.pos_reference_buffer_sel, ctrl_r.neg_reference_buffer_sel,
    ctrl_r.pos_input_precharge_disable, ctrl_r.neg_input_precharge_disable}
    == {wd_r[15:12], wd_r[9:8]}) else $error("buffer write");
  a_cm_wr_lands: assert property (s_cm_wr ##1 !(req.wr && req.addr == 8'h17) |=>
    {ctrl_r.chop_fast_sel, ctrl_r.common_mode_out_sel} == {wd_r[15], wd_r[10:8]})
    else $error("cm write");
endmodule
bind afecr_regs afecr_regs_sva chk (.clk(clk), .reset(reset), .req(req), .rsp_r(rsp_r),
  .ctrl_r(ctrl_r));

// ==== testbench/afecr_host_model.sv ====
// Host model issuing register reads and writes
`timescale 1ns/1ps
module afecr_host_model (
  // Clock
  input wire logic                     clk,
  // Access port
  output afecr_pkg::afecr_req_type     req,
  input wire afecr_pkg::afecr_rsp_type rsp_r
);
  initial req = '0;
  // Released address and data flip, so stale values never look valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
    v = rsp_r.valid;
    d = rsp_r.data;
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the front end config registers
`timescale 1ns/1ps
module tb;
  logic                      clk = 1'b0;
  logic                      reset = 1'b1;
  afecr_pkg::afecr_req_type  req;
  afecr_pkg::afecr_rsp_type  rsp_r;
  afecr_pkg::afecr_ctrl_type ctrl_r;
  int                        err_count = 0;
  int                        n_checks = 0;
  logic [7:0]                rd_data;
  logic                      rd_valid;
  logic [7:0]                exp_buf = 8'h00;
  logic [7:0]                exp_cm = 8'h00;
  always #2.5 clk = ~clk;
  afecr_regs dut (.clk(clk), .reset(reset), .req(req), .rsp_r(rsp_r), .ctrl_r(ctrl_r));
  afecr_host_model host (.clk(clk), .req(req), .rsp_r(rsp_r));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.read(a, rd_data, rd_valid);
    chk("valid", {7'h00, rd_valid}, 8'h01);
    chk("data", rd_data, exp);
  endtask
  function automatic logic [3:0] refx(input logic [1:0] c);
    return {c, c == 2'h0, c == 2'h2};
  endfunction
  task automatic chk_all();
    chk("pos ref", {4'h0, ctrl_r.pos_reference_buffer_sel, ctrl_r.pos_ref_precharge_en,
      ctrl_r.pos_ref_full_en}, {4'h0, refx(exp_buf[7:6])});
    chk("neg ref", {4'h0, ctrl_r.neg_reference_buffer_sel, ctrl_r.neg_ref_precharge_en,
      ctrl_r.neg_ref_full_en}, {4'h0, refx(exp_buf[5:4])});
    chk("in dis", {6'h00, ctrl_r.pos_input_precharge_disable,
      ctrl_r.neg_input_precharge_disable}, {6'h00, exp_buf[1:0]});
    chk("chop", {1'b0, ctrl_r.chop_fast_sel, ctrl_r.chop_divide},
      {1'b0, exp_cm[7], exp_cm[7] ? 6'h08 : 6'h20});
    chk("cm", {3'h0, ctrl_r.common_mode_out_sel, ctrl_r.common_mode_out_en,
      ctrl_r.common_mode_half_supply},
      {3'h0, exp_cm[2:0], exp_cm[2:0] != 3'h7, exp_cm[2:0] == 3'h0});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // Main sequence; reserved bits are always written as ones
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    for (int k = 0; k < 2; k++) begin
      rd_chk(8'h16, 8'h00);
      rd_chk(8'h17, 8'h00);
      chk_all();
      for (int i = 0; i < 4; i++) begin
        exp_buf = {i[1:0], ~i[1:0], 2'h0, i[0], ~i[0]};
        host.write(8'h16, exp_buf | 8'h0c);
        rd_chk(8'h16, exp_buf);
        chk_all();
      end
      for (int i = 0; i < 8; i++) begin
        exp_cm = {i[0], 4'h0, i[2:0]};
        host.write(8'h17, exp_cm | 8'h78);
        rd_chk(8'h17, exp_cm);
        chk_all();
      end
      host.write(8'h18, 8'hff);
      rd_chk(8'h18, 8'h00);
      rd_chk(8'h16, exp_buf);
      rd_chk(8'h17, exp_cm);
      // A second reset mid-run must clear everything again
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      exp_buf = 8'h00;
      exp_cm = 8'h00;
    end
    wrap_up();
  end
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule
